// ---- src/csca_accum.sv ----
// csca_accum: sums 1..64 samples of one channel and returns the average.
// assumes samples arrive as one-cycle valid pulses.
`timescale 1ns/1ps
module csca_accum #(
    parameter int SAMPLE_W = 16
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 resetn,
    // control
    input  wire logic [2:0]           acu_sel,
    input  wire logic                 restart,
    // sample in
    input  wire csca_pkg::csca_sample_s sample,
    // average out
    output logic                      avg_valid,
    output logic [SAMPLE_W-1:0]       avg_data
);
    logic [SAMPLE_W+5:0] sum_q;
    logic [6:0]          cnt_q;
    logic [SAMPLE_W+5:0] sum_new;

    function automatic logic [2:0] shift_of(input logic [2:0] sel);
        unique case (sel)
            3'h0:    shift_of = 3'h0;
            3'h1:    shift_of = 3'h2;
            3'h2:    shift_of = 3'h3;
            3'h3:    shift_of = 3'h4;
            3'h4:    shift_of = 3'h5;
            default: shift_of = 3'h6;
        endcase
    endfunction

    assign sum_new = sum_q + {6'h00, sample.data};

    // RULE6: sample count select
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sum_q     <= '0;
            cnt_q     <= 7'h00;
            avg_valid <= 1'b0;
            avg_data  <= '0;
        end else begin
            avg_valid <= 1'b0;
            if (restart) begin
                // RULE19: clear per channel
                sum_q <= '0;
                cnt_q <= 7'h00;
            end else if (sample.valid) begin
                if (cnt_q + 7'h01 == (7'h01 << shift_of(acu_sel))) begin
                    // RULE7: divide and publish
                    // RULE18: truncating right shift
                    avg_data  <= SAMPLE_W'(sum_new >> shift_of(acu_sel));
                    avg_valid <= 1'b1;
                    sum_q     <= '0;
                    cnt_q     <= 7'h00;
                end else begin
                    sum_q <= sum_new;
                    cnt_q <= cnt_q + 7'h01;
                end
            end
        end
    end
endmodule

// ---- src/csca_pkg.sv ----
// csca_pkg: register map, field positions, reset values and carriers for
// the capacitive-sense compare and accumulate block.
// assumes an 8-bit register port with one-cycle read latency.
package csca_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // register offsets
    localparam logic [3:0] SENSE_CONTROL_REG_OFF = 4'h0;
    localparam logic [3:0] SENSE_CONFIG_REG_OFF  = 4'h1;
    localparam logic [3:0] RESULT_LOW_OFF        = 4'h2;
    localparam logic [3:0] RESULT_HIGH_OFF       = 4'h3;
    localparam logic [3:0] THRESHOLD_LOW_OFF     = 4'h4;
    localparam logic [3:0] THRESHOLD_HIGH_OFF    = 4'h5;
    localparam logic [3:0] CHANNEL_MUX_OFF       = 4'h6;
    localparam logic [3:0] SCAN_START_OFF        = 4'h7;
    localparam logic [3:0] SCAN_END_OFF          = 4'h8;
    localparam logic [3:0] PIN_MONITOR_OFF       = 4'h9;
    localparam logic [3:0] IRQ_ENABLE_OFF        = 4'ha;
    // control register bits
    localparam int CTL_ENABLE_BIT  = 7;
    localparam int CTL_DONE_BIT    = 5;
    localparam int CTL_BUSY_BIT    = 4;
    localparam int CTL_CMPEN_BIT   = 3;
    localparam int CTL_PME_BIT     = 1;
    localparam int CTL_GT_BIT      = 0;
    // config register fields
    localparam int CFG_MODE_LSB    = 4;
    localparam int CFG_ACU_LSB     = 0;
    localparam logic [2:0] MODE_AUTOSCAN = 3'h7;
    // pin monitor register fields
    localparam int PM_SMBUS_BIT    = 7;
    localparam int PM_SPI_BIT      = 6;
    localparam int PM_PORT_BIT     = 5;
    localparam int PM_LIMIT_LSB    = 0;
    localparam logic [1:0] LIMIT_NONE = 2'h0;
    localparam logic [1:0] LIMIT_TWO  = 2'h1;
    localparam logic [1:0] LIMIT_FOUR = 2'h2;
    localparam logic [2:0] RETRY_TWO  = 3'h2;
    localparam logic [2:0] RETRY_FOUR = 3'h4;
    // irq enable register bits
    localparam int IE_DONE_BIT     = 0;
    localparam int IE_GT_BIT       = 5;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [4:0] CHAN_RESET = 5'h00;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } csca_bus_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } csca_sample_s;
endpackage

// ---- src/csca_retry.sv ----
// csca_retry: pin-monitor retry arbitration for one conversion.
// assumes output-switch events and conversion start are one-cycle pulses.
`timescale 1ns/1ps
module csca_retry (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // enables and limit
    input  wire logic       smbus_en,
    input  wire logic       spi_en,
    input  wire logic       port_en,
    input  wire logic [1:0] limit,
    // events
    input  wire logic       conv_start,
    input  wire logic       smbus_sw,
    input  wire logic       spi_sw,
    input  wire logic       port_wr,
    // retry request
    output logic            retry
);
    logic [2:0] used_q;
    logic       hit;
    logic       allow;

    assign hit = (smbus_en & smbus_sw) | (spi_en & spi_sw)
               | (port_en & port_wr);
    // RULE12: retry cap
    assign allow =
        (limit == csca_pkg::LIMIT_TWO)  ? used_q < csca_pkg::RETRY_TWO  :
        (limit == csca_pkg::LIMIT_FOUR) ? used_q < csca_pkg::RETRY_FOUR :
        1'b1;

    // RULE10: repeat corrupted portion
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            used_q <= 3'h0;
            retry  <= 1'b0;
        end else begin
            retry <= hit & allow & ~conv_start;
            if (conv_start)
                used_q <= 3'h0;
            else if (hit && allow && used_q != 3'h7)
                used_q <= used_q + 3'h1;
        end
    end
endmodule

// ---- src/csca_top.sv ----
// csca_top: capacitive-sense result post-processing: accumulate, average,
// threshold compare, auto-scan mux steering and pin-monitor retry.
// assumes raw conversion results arrive from the analog front end as
// one-cycle pulses, and register port signals are synchronous to clk.
//
// How it works
// RULE1: flag follows result above threshold
// RULE2: compare only after final sample
// RULE3: flag set raises enabled irq
// RULE4: flag stops autoscan until busy write
// RULE5: greater-than wakes from suspend always
// RULE6: three-bit field selects sample count
// RULE7: sum divided by count into result
// RULE8: compare averaged result, stop scan
// RULE9: hold mux on hit, else advance
// RULE10: repeat portions hit by switching
// RULE11: three monitor enables reset disabled
// RULE12: retry cap none, two or four
// RULE13: sticky event flag on any retry
// RULE14: software enables monitors sparingly
// RULE15: done irq after last sample
// RULE16: comparator enable gates compare, reset zero
// RULE17: busy write resumes halted scan
// RULE18: division is truncating right shift
// RULE19: accumulator clears per channel
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
module csca_top #(
    parameter int SAMPLE_W = 16,
    parameter int CHAN_W   = 5
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                resetn,
    // register port
    input  wire logic [3:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic [7:0]               reg_rdata,
    // front end
    input  wire logic                raw_valid,
    input  wire logic [SAMPLE_W-1:0] raw_data,
    output logic                     conv_start,
    output logic                     conv_retry,
    output logic [CHAN_W-1:0]        channel_mux_select,
    // output-switch events
    input  wire logic                smbus_switch,
    input  wire logic                spi_switch,
    input  wire logic                port_write,
    // system
    output logic                     greater_than_irq,
    output logic                     conversion_done_irq,
    output logic                     suspend_wake
);
    csca_pkg::csca_bus_s    bus;
    csca_pkg::csca_sample_s smp;
    logic        sense_enable_bit;
    logic [7:0]  sense_config_reg;
    logic [7:0]  pin_monitor_control_reg;
    logic [7:0]  extended_irq_enable_reg;
    logic [7:0]  threshold_low_byte;
    logic [7:0]  threshold_high_byte;
    logic [15:0] result_q;
    logic [CHAN_W-1:0] scan_start_channel;
    logic [CHAN_W-1:0] scan_end_channel;
    logic        convert_busy_bit;
    logic        greater_than_flag;
    logic        conversion_done_flag;
    logic        pin_monitor_event_flag;
    logic        comparator_enable_bit;
    logic        avg_valid;
    logic [SAMPLE_W-1:0] avg_data;
    logic        retry;
    logic        gt_now;
    logic        scan_hit;
    logic        autoscan;
    logic        busy_write;
    logic        restart_q;
    logic        ctl_write;

    assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
    assign smp = '{valid: raw_valid, data: raw_data};
    assign ctl_write  = bus.wr && bus.addr == csca_pkg::SENSE_CONTROL_REG_OFF;
    assign busy_write = ctl_write && bus.wdata[csca_pkg::CTL_BUSY_BIT];
    assign autoscan = sense_config_reg[csca_pkg::CFG_MODE_LSB +: 3]
                      == csca_pkg::MODE_AUTOSCAN;
    // RULE8: compare averaged value
    assign gt_now = avg_data > {threshold_high_byte, threshold_low_byte};
    // a disabled comparator never halts a scan and never wakes
    assign scan_hit = comparator_enable_bit && gt_now;

    csca_accum #(
        .SAMPLE_W (SAMPLE_W)
    ) u_accum (
        .clk       (clk),
        .resetn    (resetn),
        .acu_sel   (sense_config_reg[csca_pkg::CFG_ACU_LSB +: 3]),
        .restart   (restart_q),
        .sample    (smp),
        .avg_valid (avg_valid),
        .avg_data  (avg_data)
    );

    csca_retry u_retry (
        .clk        (clk),
        .resetn     (resetn),
        .smbus_en   (pin_monitor_control_reg[csca_pkg::PM_SMBUS_BIT]),
        .spi_en     (pin_monitor_control_reg[csca_pkg::PM_SPI_BIT]),
        .port_en    (pin_monitor_control_reg[csca_pkg::PM_PORT_BIT]),
        .limit      (pin_monitor_control_reg[csca_pkg::PM_LIMIT_LSB +: 2]),
        .conv_start (conv_start),
        .smbus_sw   (smbus_switch),
        .spi_sw     (spi_switch),
        .port_wr    (port_write),
        .retry      (retry)
    );

    // plain configuration registers
    // RULE11: monitor enables reset zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sense_config_reg        <= csca_pkg::RESET_BYTE;
            pin_monitor_control_reg <= csca_pkg::RESET_BYTE;
            extended_irq_enable_reg <= csca_pkg::RESET_BYTE;
            threshold_low_byte      <= csca_pkg::RESET_BYTE;
            threshold_high_byte     <= csca_pkg::RESET_BYTE;
            scan_start_channel      <= csca_pkg::CHAN_RESET;
            scan_end_channel        <= csca_pkg::CHAN_RESET;
        end else if (bus.wr) begin
            unique case (bus.addr)
                csca_pkg::SENSE_CONFIG_REG_OFF:
                    sense_config_reg <= bus.wdata & 8'h77;
                csca_pkg::PIN_MONITOR_OFF:
                    pin_monitor_control_reg <= bus.wdata & 8'he3;
                csca_pkg::IRQ_ENABLE_OFF:
                    extended_irq_enable_reg <= bus.wdata;
                csca_pkg::THRESHOLD_LOW_OFF:  threshold_low_byte  <= bus.wdata;
                csca_pkg::THRESHOLD_HIGH_OFF: threshold_high_byte <= bus.wdata;
                csca_pkg::SCAN_START_OFF:
                    scan_start_channel <= bus.wdata[CHAN_W-1:0];
                csca_pkg::SCAN_END_OFF:
                    scan_end_channel <= bus.wdata[CHAN_W-1:0];
                default: ;
            endcase
        end
    end

    // RULE16: comparator enable, reset zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            comparator_enable_bit <= 1'b0;
        else if (ctl_write)
            comparator_enable_bit <= bus.wdata[csca_pkg::CTL_CMPEN_BIT];
    end

    // software-owned enable bit, read back only
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            sense_enable_bit <= 1'b0;
        else if (ctl_write)
            sense_enable_bit <= bus.wdata[csca_pkg::CTL_ENABLE_BIT];
    end

    // comparison result flag
    // a compare in the same cycle outranks a software clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            greater_than_flag <= 1'b0;
        end else if (avg_valid && comparator_enable_bit) begin
            // RULE1: set or clear on compare
            // RULE2: compare after last sample
            greater_than_flag <= gt_now;
        end else if (ctl_write && !bus.wdata[csca_pkg::CTL_GT_BIT]) begin
            greater_than_flag <= 1'b0;
        end
    end

    // RULE15: done after full set
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            conversion_done_flag <= 1'b0;
        else if (avg_valid)
            conversion_done_flag <= 1'b1;
        else if (ctl_write && !bus.wdata[csca_pkg::CTL_DONE_BIT])
            conversion_done_flag <= 1'b0;
    end

    // RULE13: sticky retry event
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            pin_monitor_event_flag <= 1'b0;
        else if (retry)
            pin_monitor_event_flag <= 1'b1;
        else if (ctl_write && !bus.wdata[csca_pkg::CTL_PME_BIT])
            pin_monitor_event_flag <= 1'b0;
    end

    // result pair, loaded with each finished average
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            result_q <= 16'h0000;
        else if (avg_valid)
            result_q <= 16'(avg_data);
    end

    // busy and conversion sequencing
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            convert_busy_bit <= 1'b0;
            conv_start       <= 1'b0;
            restart_q        <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            restart_q  <= 1'b0;
            if (busy_write) begin
                // RULE17: resume from halted channel
                convert_busy_bit <= 1'b1;
                conv_start       <= 1'b1;
                restart_q        <= 1'b1;
            end else if (avg_valid) begin
                if (autoscan && !scan_hit) begin
                    conv_start <= 1'b1;
                    restart_q  <= 1'b1;
                end else begin
                    // RULE4: halt scan on hit
                    convert_busy_bit <= 1'b0;
                end
            end else if (raw_valid && convert_busy_bit) begin
                conv_start <= 1'b1;
            end
        end
    end

    // RULE9: mux hold or advance
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            channel_mux_select <= csca_pkg::CHAN_RESET;
        end else if (bus.wr && bus.addr == csca_pkg::CHANNEL_MUX_OFF) begin
            channel_mux_select <= bus.wdata[CHAN_W-1:0];
        end else if (bus.wr && bus.addr == csca_pkg::SCAN_START_OFF
                     && autoscan) begin
            channel_mux_select <= bus.wdata[CHAN_W-1:0];
        end else if (avg_valid && autoscan
                     && !scan_hit) begin
            if (channel_mux_select >= scan_end_channel)
                channel_mux_select <= scan_start_channel;
            else
                channel_mux_select <= channel_mux_select + CHAN_W'(1);
        end
    end

    // interrupt, wake and retry outputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            greater_than_irq    <= 1'b0;
            conversion_done_irq <= 1'b0;
            suspend_wake        <= 1'b0;
            conv_retry          <= 1'b0;
        end else begin
            // RULE3: gated greater-than irq
            greater_than_irq <= greater_than_flag
                && extended_irq_enable_reg[csca_pkg::IE_GT_BIT];
            conversion_done_irq <= conversion_done_flag
                && extended_irq_enable_reg[csca_pkg::IE_DONE_BIT];
            // RULE5: wake regardless of irq enable
            suspend_wake <= avg_valid && scan_hit;
            conv_retry   <= retry;
        end
    end

    // read port, one cycle latency
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (bus.rd) begin
            unique case (bus.addr)
                csca_pkg::SENSE_CONTROL_REG_OFF:
                    reg_rdata <= {sense_enable_bit, 1'b0,
                                  conversion_done_flag, convert_busy_bit,
                                  comparator_enable_bit, 1'b0,
                                  pin_monitor_event_flag, greater_than_flag};
                csca_pkg::SENSE_CONFIG_REG_OFF: reg_rdata <= sense_config_reg;
                csca_pkg::RESULT_LOW_OFF:       reg_rdata <= result_q[7:0];
                csca_pkg::RESULT_HIGH_OFF:      reg_rdata <= result_q[15:8];
                csca_pkg::THRESHOLD_LOW_OFF:
                    reg_rdata <= threshold_low_byte;
                csca_pkg::THRESHOLD_HIGH_OFF:
                    reg_rdata <= threshold_high_byte;
                csca_pkg::CHANNEL_MUX_OFF:
                    reg_rdata <= 8'(channel_mux_select);
                csca_pkg::SCAN_START_OFF: reg_rdata <= 8'(scan_start_channel);
                csca_pkg::SCAN_END_OFF:   reg_rdata <= 8'(scan_end_channel);
                csca_pkg::PIN_MONITOR_OFF:
                    reg_rdata <= pin_monitor_control_reg;
                csca_pkg::IRQ_ENABLE_OFF:
                    reg_rdata <= extended_irq_enable_reg;
                default:                   reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule

// ---- tb/csca_top_properties.sv ----
// csca_top_properties: port-level timing checks for csca_top.
// assumes one clock and the async active-low reset of the design.
`timescale 1ns/1ps
module csca_top_properties #(
    parameter int SAMPLE_W = 16,
    parameter int CHAN_W   = 5
) (
    // clock and reset
    input wire logic                clk,
    input wire logic                resetn,
    // register port
    input wire logic [3:0]          reg_addr,
    input wire logic [7:0]          reg_wdata,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [7:0]          reg_rdata,
    // front end
    input wire logic                raw_valid,
    input wire logic [SAMPLE_W-1:0] raw_data,
    input wire logic                conv_start,
    input wire logic                conv_retry,
    input wire logic [CHAN_W-1:0]   channel_mux_select,
    // output-switch events
    input wire logic                smbus_switch,
    input wire logic                spi_switch,
    input wire logic                port_write,
    // system
    input wire logic                greater_than_irq,
    input wire logic                conversion_done_irq,
    input wire logic                suspend_wake
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic sw_any;
    assign sw_any = smbus_switch | spi_switch | port_write;

    a_wake_after_sample: assert property (
        suspend_wake |-> $past(raw_valid, 2))
        else $error("wake without a finished sample set");
    a_gt_irq_rise: assert property (
        $rose(greater_than_irq) |-> $past(suspend_wake) || $past(reg_wr, 2))
        else $error("greater-than irq rose without a hit");
    a_gt_irq_fall: assert property (
        $fell(greater_than_irq) |-> $past(raw_valid, 3) || $past(reg_wr, 2))
        else $error("greater-than irq fell without cause");
    a_done_irq_rise: assert property (
        $rose(conversion_done_irq)
        |-> $past(raw_valid, 3) || $past(reg_wr, 2))
        else $error("done irq rose without a sample");
    a_retry_cause: assert property (
        conv_retry |-> $past(sw_any) || $past(sw_any, 2) || $past(sw_any, 3))
        else $error("retry without a switch event");
    a_scan_stopped: assert property (
        suspend_wake |-> (!conv_start || $past(reg_wr)) [*5])
        else $error("conversion started after a hit");
    a_mux_held: assert property (
        suspend_wake |-> $stable(channel_mux_select) [*4])
        else $error("mux moved on a hit");
    a_busy_starts: assert property (
        reg_wr && reg_addr == csca_pkg::SENSE_CONTROL_REG_OFF
        && reg_wdata[csca_pkg::CTL_BUSY_BIT] |=> conv_start)
        else $error("busy write gave no start");
endmodule

bind csca_top csca_top_properties #(
    .SAMPLE_W(SAMPLE_W), .CHAN_W(CHAN_W)
) u_props (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .raw_valid(raw_valid), .raw_data(raw_data),
    .conv_start(conv_start), .conv_retry(conv_retry),
    .channel_mux_select(channel_mux_select),
    .smbus_switch(smbus_switch), .spi_switch(spi_switch),
    .port_write(port_write), .greater_than_irq(greater_than_irq),
    .conversion_done_irq(conversion_done_irq),
    .suspend_wake(suspend_wake)
);

// ---- tb/testbench.sv ----
// testbench: self-checking bench for csca_top.
// assumes register port and events are driven on the rising clock edge.
`timescale 1ns/1ps
module testbench;
    logic        clk, resetn, reg_wr, reg_rd, rd_pend;
    logic        raw_valid, conv_start, conv_retry;
    logic        gt_irq, done_irq, wake;
    logic [2:0]  sw;
    logic [3:0]  reg_addr;
    logic [4:0]  mux;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [15:0] raw_data, avg, th, s [64];
    logic [15:0] exp_q [$];
    logic [31:0] sum;
    logic [7:0]  pm [4] = '{8'h00, 8'h80, 8'h41, 8'h22};
    int          nr [4] = '{0, 5, 2, 4};
    int          miscompares, n_checks, cyc, sh, ew, n0;
    int          n_start, n_retry, n_wake;

    csca_top dut (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .raw_valid(raw_valid), .raw_data(raw_data),
        .conv_start(conv_start), .conv_retry(conv_retry),
        .channel_mux_select(mux), .smbus_switch(sw[0]),
        .spi_switch(sw[1]), .port_write(sw[2]), .greater_than_irq(gt_irq),
        .conversion_done_irq(done_irq), .suspend_wake(wake)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e,
                      input logic [7:0] m);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        exp_q.push_back({m, e & m});
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    task automatic wctl(input logic [7:0] d);
        wr(csca_pkg::SENSE_CONTROL_REG_OFF, d);
    endtask
    task automatic rctl(input logic [7:0] e, input logic [7:0] m);
        rd(csca_pkg::SENSE_CONTROL_REG_OFF, e, m);
    endtask
    task automatic smp(input logic [15:0] d);
        @(posedge clk);
        raw_valid <= 1'b1;
        raw_data  <= d;
        @(posedge clk);
        raw_valid <= 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic test_done;
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always #12.5 clk = ~clk;
    // pulse counters, read-slot marker and hang guard
    always @(posedge clk) begin
        rd_pend <= reg_rd;
        n_start <= n_start + int'(conv_start);
        n_retry <= n_retry + int'(conv_retry);
        n_wake  <= n_wake + int'(wake);
        cyc     <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            test_done();
        end
    end
    always @(negedge clk) begin
        if (rd_pend) begin
            check(reg_rdata & exp_q[0][15:8], exp_q[0][7:0]);
            void'(exp_q.pop_front());
        end
    end

    initial begin
        clk = 0;
        resetn = 0;
        reg_wr = 0;
        reg_rd = 0;
        reg_addr = 0;
        reg_wdata = 0;
        raw_valid = 0;
        raw_data = 0;
        sw = 0;
        rd_pend = 0;
        miscompares = 0;
        n_checks = 0;
        cyc = 0;
        ew = 0;
        n_start = 0;
        n_retry = 0;
        n_wake = 0;
        void'($urandom(70352));
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        // reset values, unmapped and flag bits
        wr(4'hf, 8'hff);
        wctl(8'h47);
        for (int a = 0; a < 16; a++) rd(a[3:0], 8'h00, 8'hff);
        $display("test reset done");
        wr(csca_pkg::IRQ_ENABLE_OFF, 8'h21);
        for (int i = 0; i < 8; i++) begin
            sh  = (i == 0) ? 0 : (i > 4 ? 6 : i + 1);
            sum = 0;
            for (int k = 0; k < (1 << sh); k++) begin
                s[k] = 16'($urandom_range(16'hffff, 16'h0100));
                sum += s[k];
            end
            avg = 16'(sum >> sh);
            th  = avg - 16'(i % 2);
            ew += i % 2;
            wr(csca_pkg::THRESHOLD_LOW_OFF, th[7:0]);
            wr(csca_pkg::THRESHOLD_HIGH_OFF, th[15:8]);
            wr(csca_pkg::SENSE_CONFIG_REG_OFF, 8'(i));
            wctl(8'h98);
            for (int k = 0; k < (1 << sh); k++) smp(s[k]);
            idle(4);
            check(gt_irq, 16'(i % 2));
            check(done_irq, 16'h0001);
            check(n_wake, ew);
            rd(csca_pkg::RESULT_LOW_OFF, avg[7:0], 8'hff);
            rd(csca_pkg::RESULT_HIGH_OFF, avg[15:8], 8'hff);
            rctl(8'ha8 | 8'(i % 2), 8'hff);
        end
        $display("test accumulate done");
        // comparator off gives no flag and no wake
        wr(csca_pkg::SENSE_CONFIG_REG_OFF, 8'h00);
        wctl(8'h10);
        smp(16'hffff);
        idle(4);
        rctl(8'h20, 8'hff);
        check(n_wake, ew);
        $display("test comparator off done");
        wr(csca_pkg::IRQ_ENABLE_OFF, 8'h00);
        wr(csca_pkg::THRESHOLD_LOW_OFF, 8'h00);
        wr(csca_pkg::THRESHOLD_HIGH_OFF, 8'h80);
        wr(csca_pkg::SENSE_CONFIG_REG_OFF, 8'h70);
        wr(csca_pkg::SCAN_END_OFF, 8'h04);
        wr(csca_pkg::SCAN_START_OFF, 8'h02);
        idle(1);
        check(mux, 16'h0002);
        wctl(8'h18);
        for (int k = 3; k < 8; k++) begin
            smp(16'h8000);
            idle(4);
            check(mux, 16'(k > 4 ? k - 3 : k));
        end
        smp(16'h8001);
        idle(4);
        n0 = n_start;
        idle(8);
        check(n_start, n0);
        check(mux, 16'h0004);
        check(n_wake, ew + 1);
        check(gt_irq, 16'h0000);
        rctl(8'h01, 8'h01);
        wctl(8'h18);
        idle(2);
        check(n_start, n0 + 1);
        check(mux, 16'h0004);
        $display("test autoscan done");
        resetn <= 1'b0;
        idle(2);
        resetn <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            wr(csca_pkg::PIN_MONITOR_OFF, pm[c]);
            wctl(8'h10);
            n0 = n_retry;
            for (int r = 0; r < 15; r++) begin
                @(posedge clk) sw <= 3'h1 << (r % 3);
                @(posedge clk) sw <= 3'h0;
                idle(4);
            end
            check(n_retry, n0 + nr[c]);
            smp(16'h0000);
            idle(4);
            rctl((c > 0) ? 8'h02 : 8'h00, 8'h02);
        end
        wctl(8'h00);
        rctl(8'h00, 8'h02);
        idle(3);
        $display("test pin monitor done");
        test_done();
    end
endmodule
